// [dram_pattern_register_access.sv]
// Pattern register access logic of the DRAM: command decode, pattern store,
// read launch, protocol error flags and crossings to the system clock.
// Assumes command pins change on the link clock; config and clears come on clk.
`timescale 1ns/1ps

module dram_pattern_register_access
   import dpr_pkg::*;
#(
   parameter int DQ_W           = DQ_W_DEF,
   parameter int WR_RECOV_CYC   = WR_RECOV_CYC_DEF,
   parameter int EXIT_RECOV_CYC = EXIT_RECOV_CYC_DEF
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             clkEn,
   input  wire logic             linkClk,
   input  wire logic             csN,
   input  wire logic             actN,
   input  wire logic             rasN,
   input  wire logic             casN,
   input  wire logic             weN,
   input  wire logic [1:0]       bankAddrBits,
   input  wire logic [1:0]       bankGroupBits,
   input  wire logic [13:0]      addr,
   input  wire logic [LAT_W-1:0] cfgReadLat,
   input  wire logic             cfgParityEn,
   input  wire logic [2:0]       cfgParityLat,
   input  wire logic [ERR_W-1:0] errClear,
   output logic      [DQ_W-1:0]  dq,
   output logic                  dqOe,
   output logic                  patternModeActive,
   output logic      [1:0]       readFormat,
   output logic      [1:0]       patternPage,
   output logic      [ERR_W-1:0] errStatus
);
   localparam logic [CNT_W-1:0] WR_RECOV_LD   = CNT_W'(WR_RECOV_CYC);
   localparam logic [CNT_W-1:0] EXIT_RECOV_LD = CNT_W'(EXIT_RECOV_CYC);
   localparam logic [CNT_W-1:0] BURST_LD      = CNT_W'(BURST_BEATS);

   // Link domain: reset, enable and config synchronisers
   logic             linkRstS1_q;
   logic             linkRst_q;
   logic             linkEnS1_q;
   logic             linkEn_q;
   logic [LAT_W-1:0] latS1_q;
   logic [LAT_W-1:0] lat_q;
   logic             parEnS1_q;
   logic             parEn_q;
   logic [2:0]       parLatS1_q;
   logic [2:0]       parLat_q;

   // Link domain: mode shadow and pattern store
   logic             patEn_q;
   logic [1:0]       page_q;
   logic [1:0]       fmt_q;
   logic [1:0]       burstLen_q;
   logic [7:0]       pat_q [PAT_LOCS];
   logic [CNT_W-1:0] wrRecov_q;
   logic [CNT_W-1:0] exitRecov_q;
   logic [CNT_W-1:0] exitRecov_d;
   logic [ERR_W-1:0] errTgl_q;

   // Link domain: status word handshake, sender side
   logic [4:0]       hsData_q;
   logic             hsReq_q;
   logic             ackS1_q;
   logic             ackS2_q;

   // System domain
   logic             modeS1_q;
   logic             modeS2_q;
   logic [ERR_W-1:0] errS1_q;
   logic [ERR_W-1:0] errS2_q;
   logic [ERR_W-1:0] errS3_q;
   logic [ERR_W-1:0] errStatus_q;
   logic             reqS1_q;
   logic             reqS2_q;
   logic             reqS3_q;
   logic             ack_q;
   logic [1:0]       fmtOut_q;
   logic [1:0]       pageOut_q;

   // Command decode; only the listed address bits are looked at
   wire       cmdSel   = !csN && actN;
   wire [2:0] cmdCode  = {rasN, casN, weN};
   wire       isAct    = !csN && !actN;
   wire       isMrs    = cmdSel && (cmdCode == CMD_MRS);
   wire       isRd     = cmdSel && (cmdCode == CMD_RD);
   wire       isWr     = cmdSel && (cmdCode == CMD_WR);
   wire [2:0] mrSel    = {bankGroupBits[0], bankAddrBits};
   wire       mode3Wr  = isMrs && (mrSel == MR_SEL_THREE);
   wire       mode0Wr  = isMrs && (mrSel == MR_SEL_ZERO);
   wire       patRead  = isRd && patEn_q;
   wire       patWrite = isWr && patEn_q && (page_q == PAGE_ZERO);
   wire       chopMode = (burstLen_q == BL_CHOP4);
   wire       exitCmd  = mode3Wr && patEn_q && !addr[MODE3_PAT_EN_BIT];

   wire [LAT_W-1:0] parAdd  = parEn_q ? LAT_W'(parLat_q) : '0;
   wire [LAT_W-1:0] readLat = lat_q + parAdd;
   wire [CNT_W-1:0] rdExit  = CNT_W'(readLat) + BURST_LD + EXIT_RECOV_LD;

   // Error events, one-cycle pulses on the link clock
   wire             colLowBad = patRead && ((addr[1:0] != 2'h0) || (addr[COL_HALF_BIT] && !chopMode));
   wire             chopBad   = patRead && (burstLen_q == BL_OTF) && !addr[BURST_CHOP_BIT];
   wire             wrPageBad = isWr && patEn_q && (page_q != PAGE_ZERO);
   wire             wrEarly   = !csN && (wrRecov_q != '0);
   wire             exitEarly = exitCmd && (exitRecov_q != '0);
   wire             actBad    = isAct && patEn_q;
   wire [ERR_W-1:0] errPulse  = {exitEarly, wrEarly, chopBad, colLowBad, wrPageBad, actBad};

   wire [4:0] hsCur  = {patEn_q, fmt_q, page_q};
   wire       hsIdle = (ackS2_q == hsReq_q);

   // Enable and reset synchronisers run freely so that they can see release
   always_ff @(posedge linkClk) begin
      linkRstS1_q <= sys_rst;
      linkRst_q <= linkRstS1_q;
      linkEnS1_q <= clkEn;
      linkEn_q <= linkEnS1_q;
   end

   // Config is quasi-static; bits may settle over two link cycles after a change
   always_ff @(posedge linkClk) begin
      if (linkRst_q) begin
         latS1_q <= '0;
         lat_q <= '0;
         parEnS1_q <= 1'b0;
         parEn_q <= 1'b0;
         parLatS1_q <= 3'h0;
         parLat_q <= 3'h0;
      end else if (linkEn_q) begin
         latS1_q <= cfgReadLat;
         lat_q <= latS1_q;
         parEnS1_q <= cfgParityEn;
         parEn_q <= parEnS1_q;
         parLatS1_q <= cfgParityLat;
         parLat_q <= parLatS1_q;
      end
   end

   // Mode register shadow; exit takes effect at once so the next command is normal
   always_ff @(posedge linkClk) begin
      if (linkRst_q) begin
         patEn_q <= 1'b0;
         page_q <= PAGE_RST;
         fmt_q <= FMT_RST;
         burstLen_q <= BL_RST;
      end else if (linkEn_q) begin
         if (mode3Wr) begin
            patEn_q <= addr[MODE3_PAT_EN_BIT];
            page_q <= addr[MODE3_PAGE_LSB +: 2];
            fmt_q <= addr[MODE3_FMT_LSB +: 2];
         end
         if (mode0Wr) begin
            burstLen_q <= addr[MODE0_BL_LSB +: 2];
         end
      end
   end

   // Pattern store; reset is the only thing that restores the initial values
   always_ff @(posedge linkClk) begin
      if (linkRst_q) begin
         for (int k = 0; k < PAT_LOCS; k++) begin
            pat_q[k] <= PAT_RST_VAL[8*k +: 8];
         end
      end else if (linkEn_q && patWrite) begin
         pat_q[bankAddrBits] <= addr[7:0];
      end
   end

   always_comb begin
      exitRecov_d = (exitRecov_q != '0) ? exitRecov_q - CNT_W'(1) : '0;
      if (patRead && (rdExit > exitRecov_d)) begin
         exitRecov_d = rdExit;
      end
      if (patWrite && (EXIT_RECOV_LD > exitRecov_d)) begin
         exitRecov_d = EXIT_RECOV_LD;
      end
   end

   // Recovery timers and error toggles
   always_ff @(posedge linkClk) begin
      if (linkRst_q) begin
         wrRecov_q <= '0;
         exitRecov_q <= '0;
         errTgl_q <= '0;
      end else if (linkEn_q) begin
         if (patWrite) begin
            wrRecov_q <= WR_RECOV_LD;
         end else if (wrRecov_q != '0) begin
            wrRecov_q <= wrRecov_q - CNT_W'(1);
         end
         exitRecov_q <= exitRecov_d;
         errTgl_q <= errTgl_q ^ errPulse;
      end
   end

   // Status word toward clk: data held stable until acknowledged
   always_ff @(posedge linkClk) begin
      if (linkRst_q) begin
         hsData_q <= 5'h00;
         hsReq_q <= 1'b0;
         ackS1_q <= 1'b0;
         ackS2_q <= 1'b0;
      end else if (linkEn_q) begin
         ackS1_q <= ack_q;
         ackS2_q <= ackS1_q;
         if (hsIdle && (hsCur != hsData_q)) begin
            hsData_q <= hsCur;
            hsReq_q <= !hsReq_q;
         end
      end
   end

   // Read burst engine
   dpr_burst_if #(.DQ_W(DQ_W)) burst (.linkClk(linkClk));

   assign burst.linkRst = linkRst_q;
   assign burst.run = linkEn_q;
   assign burst.reqValid = patRead;
   assign burst.reqLoc = bankAddrBits;
   assign burst.reqFmt = fmt_q;
   assign burst.reqChop = chopMode;
   assign burst.reqHalf = addr[COL_HALF_BIT];
   assign burst.latency = readLat;
   assign burst.pats = {pat_q[3], pat_q[2], pat_q[1], pat_q[0]};

   dpr_burst_engine #(
      .DQ_W(DQ_W)
   ) i_dpr_burst_engine (
      .bus(burst.eng)
   );

   // System domain: mode level, error events and the status word
   wire [ERR_W-1:0] errEdge = errS2_q ^ errS3_q;
   wire             reqNew  = reqS2_q ^ reqS3_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         modeS1_q <= 1'b0;
         modeS2_q <= 1'b0;
         errS1_q <= '0;
         errS2_q <= '0;
         errS3_q <= '0;
         errStatus_q <= '0;
      end else if (clkEn) begin
         modeS1_q <= patEn_q;
         modeS2_q <= modeS1_q;
         errS1_q <= errTgl_q;
         errS2_q <= errS1_q;
         errS3_q <= errS2_q;
         // A new event wins over a clear in the same cycle
         errStatus_q <= (errStatus_q & ~errClear) | errEdge;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reqS1_q <= 1'b0;
         reqS2_q <= 1'b0;
         reqS3_q <= 1'b0;
         ack_q <= 1'b0;
         fmtOut_q <= FMT_RST;
         pageOut_q <= PAGE_RST;
      end else if (clkEn) begin
         reqS1_q <= hsReq_q;
         reqS2_q <= reqS1_q;
         reqS3_q <= reqS2_q;
         ack_q <= reqS2_q;
         if (reqNew) begin
            fmtOut_q <= hsData_q[3:2];
            pageOut_q <= hsData_q[1:0];
         end
      end
   end

   assign dq = burst.dq;
   assign dqOe = burst.dqOe;
   assign patternModeActive = modeS2_q;
   assign readFormat = fmtOut_q;
   assign patternPage = pageOut_q;
   assign errStatus = errStatus_q;

endmodule : dram_pattern_register_access

// [dpr_pkg.sv]
// Package for the DRAM pattern register access block.
// Assumes the command pins are sampled on the link clock and the rest on clk.
package dpr_pkg;

   // Widths and depths
   localparam int DQ_W_DEF      = 8;
   localparam int LAT_W         = 6;
   localparam int MAX_LAT       = 64;
   localparam int BURST_BEATS   = 8;
   localparam int PAT_LOCS      = 4;
   localparam int CNT_W         = 8;

   // Read layouts, mode register three A[12:11]
   localparam logic [1:0] FMT_SERIAL   = 2'h0;
   localparam logic [1:0] FMT_PARALLEL = 2'h1;
   localparam logic [1:0] FMT_STAGGER  = 2'h2;

   // Burst length field, mode register zero A[1:0]
   localparam logic [1:0] BL_FIXED8 = 2'h0;
   localparam logic [1:0] BL_OTF    = 2'h1;
   localparam logic [1:0] BL_CHOP4  = 2'h2;

   localparam logic [1:0] PAGE_ZERO = 2'h0;

   // Mode register select {bank group bit 0, bank address bits}
   localparam logic [2:0] MR_SEL_ZERO  = 3'h0;
   localparam logic [2:0] MR_SEL_THREE = 3'h3;

   // Address field positions
   localparam int MODE3_PAT_EN_BIT = 2;
   localparam int MODE3_PAGE_LSB   = 0;
   localparam int MODE3_FMT_LSB    = 11;
   localparam int MODE0_BL_LSB     = 0;
   localparam int BURST_CHOP_BIT   = 12;
   localparam int COL_HALF_BIT     = 2;

   // {rasN, casN, weN} with actN high
   localparam logic [2:0] CMD_MRS = 3'h0;
   localparam logic [2:0] CMD_RD  = 3'h5;
   localparam logic [2:0] CMD_WR  = 3'h4;

   // Values after reset
   localparam logic [31:0] PAT_RST_VAL = 32'h0000_0000;
   localparam logic [1:0]  FMT_RST     = 2'h0;
   localparam logic [1:0]  PAGE_RST    = 2'h0;
   localparam logic [1:0]  BL_RST      = 2'h0;

   // Recovery counts in link clock cycles
   localparam int WR_RECOV_CYC_DEF   = 8;
   localparam int EXIT_RECOV_CYC_DEF = 8;

   // Protocol error bit positions
   localparam int ERR_ACT_IN_PAT = 0;
   localparam int ERR_WR_PAGE    = 1;
   localparam int ERR_COL_LOW    = 2;
   localparam int ERR_CHOP_BIT   = 3;
   localparam int ERR_WR_RECOV   = 4;
   localparam int ERR_EXIT_RECOV = 5;
   localparam int ERR_W          = 6;

   typedef enum logic [1:0] {
      ENG_IDLE  = 2'b01,
      ENG_BURST = 2'b10
   } dpr_eng_state_t;

endpackage : dpr_pkg

// [dpr_burst_if.sv]
// Carrier between the command side and the read burst engine.
// Assumes every signal lives on the link clock.
`timescale 1ns/1ps
interface dpr_burst_if
   import dpr_pkg::*;
#(
   parameter int DQ_W = DQ_W_DEF
) (
   input wire logic linkClk
);
   logic             linkRst;
   logic             run;
   logic             reqValid;
   logic [1:0]       reqLoc;
   logic [1:0]       reqFmt;
   logic             reqChop;
   logic             reqHalf;
   logic [LAT_W-1:0] latency;
   logic [31:0]      pats;
   logic [DQ_W-1:0]  dq;
   logic             dqOe;

   modport ctrl (input linkClk, output linkRst, run, reqValid, reqLoc, reqFmt, reqChop, reqHalf,
                 latency, pats, input dq, dqOe);
   modport eng  (input linkClk, linkRst, run, reqValid, reqLoc, reqFmt, reqChop, reqHalf,
                 latency, pats, output dq, dqOe);
endinterface : dpr_burst_if

// [dpr_burst_engine.sv]
// Read burst engine: latency pipe and lane mapping of pattern data.
// Assumes requests arrive in the cycle of the read command on the link clock.
`timescale 1ns/1ps
module dpr_burst_engine
   import dpr_pkg::*;
#(
   parameter int DQ_W = DQ_W_DEF
) (
   dpr_burst_if.eng bus
);
   logic [MAX_LAT-1:0] pipeValid_q;
   logic [1:0]         pipeLoc_q  [MAX_LAT];
   logic [1:0]         pipeFmt_q  [MAX_LAT];
   logic               pipeChop_q [MAX_LAT];
   logic               pipeHalf_q [MAX_LAT];
   dpr_eng_state_t     state_q;
   dpr_eng_state_t     state_d;
   logic [2:0]         beat_q;
   logic [1:0]         curLoc_q;
   logic [1:0]         curFmt_q;
   logic               curChop_q;
   logic               curHalf_q;
   logic [DQ_W-1:0]    dq_q;
   logic               dqOe_q;

   function automatic logic [DQ_W-1:0] laneWord(input logic [1:0] fmt, input logic [1:0] loc,
                                                input logic [2:0] beat, input logic [31:0] pats);
      logic [DQ_W-1:0] w;
      logic [1:0]      rot;
      w = '0;
      for (int j = 0; j < DQ_W; j++) begin
         rot = loc + 2'(j);
         case (fmt)
            FMT_PARALLEL: w[j] = pats[{loc, 3'(j)}];
            FMT_STAGGER:  w[j] = pats[{rot, beat}];
            default:      w[j] = pats[{loc, beat}];
         endcase
      end
      return w;
   endfunction : laneWord

   wire [LAT_W-1:0] tapIdx   = (bus.latency == '0) ? '0 : bus.latency - LAT_W'(1);
   wire             launch   = pipeValid_q[tapIdx];
   wire             lastBeat = (beat_q == 3'(BURST_BEATS - 1));
   wire             cont     = (state_q == ENG_BURST) && !lastBeat;
   wire             drive    = launch || cont;
   wire [1:0]       selLoc   = launch ? pipeLoc_q[tapIdx] : curLoc_q;
   wire [1:0]       selFmt   = launch ? pipeFmt_q[tapIdx] : curFmt_q;
   wire             selChop  = launch ? pipeChop_q[tapIdx] : curChop_q;
   wire             selHalf  = launch ? pipeHalf_q[tapIdx] : curHalf_q;
   wire [2:0]       nxtBeat  = launch ? 3'h0 : beat_q + 3'h1;
   wire [2:0]       srcBeat  = (selChop && selHalf) ? nxtBeat + 3'h4 : nxtBeat;
   wire             oeNext   = drive && !(selChop && nxtBeat[2]);

   always_comb begin
      state_d = state_q;
      case (state_q)
         ENG_IDLE:  if (launch) state_d = ENG_BURST;
         ENG_BURST: if (lastBeat && !launch) state_d = ENG_IDLE;
         default:   state_d = ENG_IDLE;
      endcase
   end

   // Latency pipe holds every read in flight, so reads may overlap the previous burst
   always_ff @(posedge bus.linkClk) begin
      if (bus.linkRst) begin
         pipeValid_q <= '0;
      end else if (bus.run) begin
         pipeValid_q <= {pipeValid_q[MAX_LAT-2:0], bus.reqValid};
         pipeLoc_q[0] <= bus.reqLoc;
         pipeFmt_q[0] <= bus.reqFmt;
         pipeChop_q[0] <= bus.reqChop;
         pipeHalf_q[0] <= bus.reqHalf;
         for (int i = 1; i < MAX_LAT; i++) begin
            pipeLoc_q[i] <= pipeLoc_q[i-1];
            pipeFmt_q[i] <= pipeFmt_q[i-1];
            pipeChop_q[i] <= pipeChop_q[i-1];
            pipeHalf_q[i] <= pipeHalf_q[i-1];
         end
      end
   end

   always_ff @(posedge bus.linkClk) begin
      if (bus.linkRst) begin
         state_q <= ENG_IDLE;
         beat_q <= 3'h0;
         curLoc_q <= 2'h0;
         curFmt_q <= FMT_RST;
         curChop_q <= 1'b0;
         curHalf_q <= 1'b0;
         dq_q <= '0;
         dqOe_q <= 1'b0;
      end else if (bus.run) begin
         state_q <= state_d;
         beat_q <= drive ? nxtBeat : 3'h0;
         curLoc_q <= selLoc;
         curFmt_q <= selFmt;
         curChop_q <= selChop;
         curHalf_q <= selHalf;
         dq_q <= oeNext ? laneWord(selFmt, selLoc, srcBeat, bus.pats) : '0;
         dqOe_q <= oeNext;
      end
   end

   assign bus.dq = dq_q;
   assign bus.dqOe = dqOe_q;

endmodule : dpr_burst_engine

// [dpr_sva.sv]
// Concurrent checks on the ports of the pattern register access block.
// Assumes it is bound to the top module; link pins are sampled on linkClk.
`timescale 1ns/1ps
module dpr_sva
   import dpr_pkg::*;
#(
   parameter int DQ_W           = DQ_W_DEF,
   parameter int WR_RECOV_CYC   = WR_RECOV_CYC_DEF,
   parameter int EXIT_RECOV_CYC = EXIT_RECOV_CYC_DEF
) (
   input wire logic             clk,
   input wire logic             sys_rst,
   input wire logic             linkClk,
   input wire logic             csN,
   input wire logic             actN,
   input wire logic             rasN,
   input wire logic             casN,
   input wire logic             weN,
   input wire logic [13:0]      addr,
   input wire logic [ERR_W-1:0] errClear,
   input wire logic [DQ_W-1:0]  dq,
   input wire logic             dqOe,
   input wire logic             patternModeActive,
   input wire logic [1:0]       readFormat,
   input wire logic [1:0]       patternPage,
   input wire logic [ERR_W-1:0] errStatus
);
   wire             sel    = !csN && actN && patternModeActive;
   wire             rdCmd  = sel && ({rasN, casN, weN} == CMD_RD);
   wire             wrCmd  = sel && ({rasN, casN, weN} == CMD_WR);
   wire             actCmd = !csN && !actN && patternModeActive;
   wire [ERR_W-1:0] held   = errStatus & ~errClear;

   a_read_latency: assert property (@(posedge linkClk) disable iff (sys_rst) rdCmd |-> ##[1:71] dqOe)
      else $error("pattern read gave no data");
   a_idle_zero: assert property (@(posedge linkClk) disable iff (sys_rst) !dqOe |-> dq == '0)
      else $error("data lanes not zero while idle");
   a_serial_lanes: assert property (@(posedge linkClk) disable iff (sys_rst)
      dqOe && readFormat[1] == readFormat[0] |-> dq == '0 || dq == '1)
      else $error("serial lanes differ");
   a_parallel_hold: assert property (@(posedge linkClk) disable iff (sys_rst)
      dqOe && $past(dqOe) && readFormat == FMT_PARALLEL |-> $stable(dq))
      else $error("parallel byte changed within stream");
   a_stagger_repeat: assert property (@(posedge linkClk) disable iff (sys_rst)
      dqOe && readFormat == FMT_STAGGER |-> dq[DQ_W-1:4] == {(DQ_W/4-1){dq[3:0]}})
      else $error("upper lanes do not repeat lower lanes");
   a_col_flag: assert property (@(posedge linkClk) disable iff (sys_rst)
      rdCmd && addr[1:0] != 2'h0 |-> ##[1:6] errStatus[ERR_COL_LOW])
      else $error("bad column bits not flagged");
   a_act_flag: assert property (@(posedge linkClk) disable iff (sys_rst)
      actCmd |-> ##[1:6] errStatus[ERR_ACT_IN_PAT])
      else $error("activate in pattern mode not flagged");
   a_page_flag: assert property (@(posedge linkClk) disable iff (sys_rst)
      wrCmd && patternPage != PAGE_ZERO |-> ##[1:6] errStatus[ERR_WR_PAGE])
      else $error("write to nonzero page not flagged");
   a_err_sticky: assert property (@(posedge clk) disable iff (sys_rst)
      held != '0 |=> (errStatus & $past(held)) == $past(held))
      else $error("error flag dropped without clear");

   c_stagger: cover property (@(posedge linkClk) dqOe && readFormat == FMT_STAGGER);
   c_stream: cover property (@(posedge linkClk) dqOe [*8] ##1 dqOe);
   c_act_err: cover property (@(posedge clk) $rose(errStatus[ERR_ACT_IN_PAT]));
endmodule : dpr_sva

bind dram_pattern_register_access dpr_sva #(.DQ_W(DQ_W), .WR_RECOV_CYC(WR_RECOV_CYC),
   .EXIT_RECOV_CYC(EXIT_RECOV_CYC)) i_dpr_sva (.clk(clk), .sys_rst(sys_rst), .linkClk(linkClk),
   .csN(csN), .actN(actN), .rasN(rasN), .casN(casN), .weN(weN), .addr(addr), .errClear(errClear),
   .dq(dq), .dqOe(dqOe), .patternModeActive(patternModeActive), .readFormat(readFormat),
   .patternPage(patternPage), .errStatus(errStatus));

// [dpr_ctrl_model.sv]
// Memory controller model that drives the command and address pins.
// Assumes a free running linkClk; the bench calls its tasks in turn.
`timescale 1ns/1ps
module dpr_ctrl_model
   import dpr_pkg::*;
(
   input  wire logic  linkClk,
   output logic       csN,
   output logic       actN,
   output logic       rasN,
   output logic       casN,
   output logic       weN,
   output logic [1:0] bankAddrBits,
   output logic [1:0] bankGroupBits,
   output logic [13:0] addr
);
   initial begin
      {csN, actN, rasN, casN, weN} = 5'h1F;
      bankAddrBits = 2'h0;
      bankGroupBits = 2'h0;
      addr = 14'h0000;
   end

   task automatic issue(input logic [3:0] c, input logic [1:0] ba, input logic [1:0] bg,
                        input logic [13:0] a, input int gap);
      @(negedge linkClk);
      {csN, actN, rasN, casN, weN} = {1'b0, c};
      bankAddrBits = ba;
      bankGroupBits = bg;
      addr = a;
      @(negedge linkClk);
      csN = 1'b1;
      // Deselected pins must not look like held values
      addr = ~addr;
      bankAddrBits = ~bankAddrBits;
      repeat (gap) @(negedge linkClk);
   endtask : issue

   // Gap covers both mode register delays
   task automatic mode3(input logic en, input logic [1:0] page, input logic [1:0] f);
      issue({1'b1, CMD_MRS}, MR_SEL_THREE[1:0], 2'h0, {1'b0, f, 8'h00, en, page}, 4);
   endtask : mode3

   task automatic mode0(input logic [1:0] bl);
      issue({1'b1, CMD_MRS}, MR_SEL_ZERO[1:0], 2'h0, {12'h000, bl}, 4);
   endtask : mode0

   // Chop bit always high; A10 follows bg[1] as a don't care
   task automatic rd(input logic [1:0] loc, input logic [2:0] col, input logic [1:0] bg);
      issue({1'b1, CMD_RD}, loc, bg, {2'h1, 1'b0, bg[1], 7'h00, col}, 0);
   endtask : rd

   // No inversion pin exists; data rides on the address only
   task automatic wr(input logic [1:0] loc, input logic [7:0] d);
      issue({1'b1, CMD_WR}, loc, 2'h0, {6'h00, d}, WR_RECOV_CYC_DEF + 2);
   endtask : wr

   task automatic act();
      issue(4'h7, 2'h0, 2'h0, 14'h0000, 2);
   endtask : act

   task automatic enter(input logic [1:0] f);
      repeat (8) @(negedge linkClk);
      mode3(1'b1, PAGE_ZERO, f);
   endtask : enter

   task automatic leave();
      repeat (24) @(negedge linkClk);
      mode3(1'b0, PAGE_ZERO, 2'h0);
   endtask : leave
endmodule : dpr_ctrl_model

// [tb_dram_pattern_register_access.sv]
// Self-checking bench for the pattern register access block.
// Assumes the controller model drives the pins; read beats are queued.
`timescale 1ns/1ps
module tb_dram_pattern_register_access;
   import dpr_pkg::*;
   typedef struct {int cyc; logic [7:0] d;} dpr_beat_t;

   logic clk = 1'b0, linkClk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1;
   logic [LAT_W-1:0] cfgReadLat = 6'h03;
   logic cfgParityEn = 1'b0;
   logic [2:0] cfgParityLat = 3'h0;
   logic [ERR_W-1:0] errClear = 6'h00, errStatus;
   logic csN, actN, rasN, casN, weN, dqOe, patternModeActive;
   logic [1:0] bankAddrBits, bankGroupBits, readFormat, patternPage, fmt = 2'h0, bl;
   logic [13:0] addr;
   logic [7:0] dq, pat [4];
   int n_errors = 0, checks_done = 0, lc = 0, seed = 9, tmo = 0;
   dpr_beat_t q[$], beat;

   dram_pattern_register_access i_dram_pattern_register_access (.clk(clk), .sys_rst(sys_rst),
      .clkEn(clkEn), .linkClk(linkClk), .csN(csN), .actN(actN), .rasN(rasN), .casN(casN),
      .weN(weN), .bankAddrBits(bankAddrBits), .bankGroupBits(bankGroupBits), .addr(addr),
      .cfgReadLat(cfgReadLat), .cfgParityEn(cfgParityEn), .cfgParityLat(cfgParityLat),
      .errClear(errClear), .dq(dq), .dqOe(dqOe), .patternModeActive(patternModeActive),
      .readFormat(readFormat), .patternPage(patternPage), .errStatus(errStatus));
   dpr_ctrl_model i_dpr_ctrl_model (.linkClk(linkClk), .csN(csN), .actN(actN), .rasN(rasN),
      .casN(casN), .weN(weN), .bankAddrBits(bankAddrBits), .bankGroupBits(bankGroupBits), .addr(addr));

   initial begin
      forever #20 clk = ~clk;
   end
   initial begin
      #13;
      forever #40 linkClk = ~linkClk;
   end
   always @(posedge linkClk) lc <= lc + 1;

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   function automatic logic [7:0] expByte(input logic [1:0] loc, input int u);
      logic [7:0] b;
      for (int j = 0; j < 8; j++) begin
         case (fmt)
            FMT_PARALLEL: b[j] = pat[loc][j];
            FMT_STAGGER:  b[j] = pat[(loc + j) % 4][u];
            default:      b[j] = pat[loc][u];
         endcase
      end
      return b;
   endfunction : expByte

   // Issue a read and note every beat it should produce
   task automatic rd(input logic [1:0] loc, input logic [2:0] col);
      int n;
      i_dpr_ctrl_model.rd(loc, col, 2'($random(seed)));
      n = (bl == BL_CHOP4) ? 4 : 8;
      for (int u = 0; u < n; u++) begin
         q.push_back('{lc + cfgReadLat + (cfgParityEn ? cfgParityLat : 0) + u, expByte(loc, u + (col[2] ? 4 : 0))});
      end
      repeat (6) @(negedge linkClk);
   endtask : rd

   task automatic stat(input logic [15:0] exp);
      repeat (4) @(negedge linkClk);
      check({10'h000, errStatus}, exp);
      @(negedge clk) errClear = 6'h3F;
      repeat (2) @(negedge clk);
      errClear = 6'h00;
   endtask : stat

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : conclude

   always @(negedge linkClk) begin
      if (q.size() > 0 && (dqOe === 1'b1 || q[0].cyc == lc)) begin
         beat = q.pop_front();
         check({7'h00, dqOe, dq}, {7'h00, 1'b1, beat.d});
         check(16'(lc), 16'(beat.cyc));
      end else if (!sys_rst && dqOe !== 1'b0) begin
         check({7'h00, dqOe, dq}, 16'h0000);
      end
   end

   always @(posedge clk) begin
      tmo <= tmo + 1;
      if (tmo == 8000) begin
         n_errors++;
         conclude();
      end
   end

   initial begin
      repeat (10) @(posedge clk);
      @(negedge clk) sys_rst = 1'b0;
      repeat (4) @(negedge linkClk);
      check({5'h00, patternModeActive, readFormat, patternPage, errStatus}, 16'h0000);
      for (int i = 0; i < 4; i++) pat[i] = 8'h00;
      bl = BL_FIXED8;
      i_dpr_ctrl_model.enter(fmt);
      rd(2'h1, 3'h0);
      for (int i = 0; i < 4; i++) begin
         pat[i] = 8'($random(seed));
         i_dpr_ctrl_model.wr(2'(i), pat[i]);
      end
      for (int f = 0; f < 4; f++) begin
         fmt = 2'(f);
         i_dpr_ctrl_model.mode3(1'b1, PAGE_ZERO, fmt);
         repeat (8) @(negedge linkClk);
         check(16'(readFormat), 16'(fmt));
         for (int i = 0; i < 6; i++) rd((fmt == FMT_PARALLEL) ? 2'h0 : 2'(i), 3'h0);
         repeat (16) @(negedge linkClk);
      end
      fmt = FMT_STAGGER;
      i_dpr_ctrl_model.mode3(1'b1, PAGE_ZERO, fmt);
      bl = BL_CHOP4;
      i_dpr_ctrl_model.mode0(bl);
      rd(2'h2, 3'h0);
      rd(2'h3, 3'h4);
      bl = BL_OTF;
      i_dpr_ctrl_model.mode0(bl);
      rd(2'h1, 3'h0);
      repeat (8) @(negedge linkClk);
      @(negedge clk) cfgParityEn = 1'b1;
      cfgParityLat = 3'h2;
      repeat (8) @(negedge linkClk);
      rd(2'h0, 3'h0);
      repeat (8) @(negedge linkClk);
      @(negedge clk) cfgParityEn = 1'b0;
      repeat (8) @(negedge linkClk);
      rd(2'h1, 3'h1);
      stat(16'h0004);
      i_dpr_ctrl_model.act();
      stat(16'h0001);
      i_dpr_ctrl_model.mode3(1'b1, 2'h1, fmt);
      repeat (8) @(negedge linkClk);
      check(16'(patternPage), 16'h0001);
      i_dpr_ctrl_model.wr(2'h0, ~pat[0]);
      stat(16'h0002);
      i_dpr_ctrl_model.mode3(1'b1, PAGE_ZERO, fmt);
      repeat (8) @(negedge linkClk);
      i_dpr_ctrl_model.issue({1'b1, CMD_WR}, 2'h3, 2'h0, {6'h00, pat[3]}, 0);
      rd(2'h0, 3'h0);
      stat(16'h0010);
      i_dpr_ctrl_model.leave();
      repeat (8) @(negedge linkClk);
      check({15'h0000, patternModeActive}, 16'h0000);
      i_dpr_ctrl_model.act();
      i_dpr_ctrl_model.rd(2'h0, 3'h0, 2'h0);
      stat(16'h0000);
      repeat (12) @(negedge linkClk);
      conclude();
   end
endmodule : tb_dram_pattern_register_access
